// >>> core/lpmc_ctrl.sv
// Low-power mode controller: run, sleep, stop, standby and battery switch
//
// Contract
// - Offer sleep, stop and standby modes
// - Sleep gates only the processor clock
// - Any peripheral interrupt or event ends sleep
// - Stop halts core clocks, PLL, both oscillators
// - Stop keeps regulator normal or low-power
// - Any interrupt-controller line ends stop
// - Standby turns regulator, PLL, oscillators off
// - Standby loses core state except backup
// - Standby exits on reset, watchdog, pin, RTC; on battery the code ignores the pin as well as RTC
// - No standby with regulator bypassed
// - Backup supply from main, else battery
// - Battery operation ignores interrupts and RTC
// - Strap open disables battery-domain operation
`timescale 1ns/1ps
module lpmc_ctrl (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic enter_req, // One-cycle request to enter a mode
	input wire lpmc_pkg::lpmc_mode_e enter_mode, // Mode requested
	input wire logic stop_lp_reg, // Regulator low-power in stop
	input wire logic periph_event, // Any peripheral interrupt or event
	input wire lpmc_pkg::lpmc_wake_s wake_src, // Async wake sources
	input wire logic wakeup_pin, // Wakeup pin, async
	input wire logic external_reset_pin_n, // Reset pin, active low
	input wire logic independent_watchdog, // Watchdog reset, async
	input wire logic regulator_bypass, // Regulator bypassed, async
	input wire logic main_supply_ok, // Main supply present, async
	input wire logic power_down_reset_strap, // Strap tied high, async
	output lpmc_pkg::lpmc_ctrl_s ctrl, // Domain controls
	output lpmc_pkg::lpmc_state_e state, // Current state
	output logic backup_from_battery, // Backup switch on battery
	output logic backup_retain // Backup domain contents kept
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 27;
	logic [NSYNC-1:0] async_in; // Raw async bundle
	logic [NSYNC-1:0] sync1_reg; // First stage, read only by second
	logic [NSYNC-1:0] sync2_reg; // Safe synchronised copy
	assign async_in = {wake_src, wakeup_pin, external_reset_pin_n,
		independent_watchdog, regulator_bypass, main_supply_ok,
		power_down_reset_strap};
	// Two flops per bit; pins come from outside the clock domain
	always_ff @(posedge mclk) begin
		sync1_reg <= async_in;
		sync2_reg <= sync1_reg;
	end
	lpmc_pkg::lpmc_wake_s wake_s; // Synced wake sources
	logic pin_s, external_reset_pin_n_s, wdg_s, bypass_s, vdd_s, strap_s;
	assign {wake_s, pin_s, external_reset_pin_n_s, wdg_s, bypass_s, vdd_s, strap_s} =
		sync2_reg;
	logic pin_prev_reg; // Wakeup pin last cycle for edge detect
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_prev_reg <= 1'b1;
		end else begin
			pin_prev_reg <= pin_s;
		end
	end
	// ------------------------------------------------------------
	// Wake decode
	// ------------------------------------------------------------
	logic battery_only; // Main supply absent
	logic rtc_any; // Any RTC event
	logic stop_wake; // Stop exit condition
	logic standby_wake; // Standby exit condition
	logic standby_ok; // Standby allowed now
	assign battery_only = ~vdd_s;
	assign rtc_any = wake_s.rtc_alarm | wake_s.rtc_wakeup |
		wake_s.rtc_tamper | wake_s.rtc_timestamp;
	// Interrupts and RTC are blind while on battery alone
	assign stop_wake = ~battery_only & ((|wake_s.ext_lines) |
		wake_s.supply_level | rtc_any);
	assign standby_wake = ~external_reset_pin_n_s | wdg_s | (~battery_only &
		((pin_s & ~pin_prev_reg) | rtc_any));
	assign standby_ok = ~bypass_s;
	// ------------------------------------------------------------
	// Mode sequencer
	// ------------------------------------------------------------
	lpmc_pkg::lpmc_state_e state_reg, state_next;
	logic [7:0] rst_cnt_reg, rst_cnt_next; // Reset sequence count
	logic lp_reg_reg, lp_reg_next; // Latched regulator choice
	always_comb begin
		state_next = state_reg;
		rst_cnt_next = rst_cnt_reg;
		lp_reg_next = lp_reg_reg;
		case (state_reg)
			lpmc_pkg::LPMC_ST_RESET: begin
				if (rst_cnt_reg == 8'h01) begin
					state_next = lpmc_pkg::LPMC_ST_RUN;
				end else begin
					rst_cnt_next = rst_cnt_reg - 8'h01;
				end
			end
			lpmc_pkg::LPMC_ST_RUN: begin
				if (enter_req) begin
					case (enter_mode)
						lpmc_pkg::LPMC_MODE_SLEEP: begin
							state_next = lpmc_pkg::LPMC_ST_SLEEP;
						end
						lpmc_pkg::LPMC_MODE_STOP: begin
							state_next = lpmc_pkg::LPMC_ST_STOP;
							lp_reg_next = stop_lp_reg;
						end
						default: begin
							// Bypassed regulator: request ignored
							if (standby_ok) begin
								state_next = lpmc_pkg::LPMC_ST_STANDBY;
							end
						end
					endcase
				end
			end
			lpmc_pkg::LPMC_ST_SLEEP: begin
				if (periph_event) begin
					state_next = lpmc_pkg::LPMC_ST_RUN;
				end
			end
			lpmc_pkg::LPMC_ST_STOP: begin
				if (stop_wake) begin
					state_next = lpmc_pkg::LPMC_ST_RUN;
				end
			end
			lpmc_pkg::LPMC_ST_STANDBY: begin
				if (standby_wake) begin
					state_next = lpmc_pkg::LPMC_ST_RESET;
					rst_cnt_next = lpmc_pkg::LPMC_RESET_CYCLES;
				end
			end
			default: begin
				state_next = lpmc_pkg::LPMC_ST_RESET;
			end
		endcase
	end
	// State registers; reset starts the full power-up sequence
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= lpmc_pkg::LPMC_ST_RESET;
			rst_cnt_reg <= lpmc_pkg::LPMC_RESET_CYCLES;
			lp_reg_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rst_cnt_reg <= rst_cnt_next;
			lp_reg_reg <= lp_reg_next;
		end
	end
	// ------------------------------------------------------------
	// Domain controls
	// ------------------------------------------------------------
	lpmc_pkg::lpmc_ctrl_s ctrl_next; // Decoded controls
	logic in_stop, in_stby, in_sleep, in_rst;
	assign in_stop = state_next == lpmc_pkg::LPMC_ST_STOP;
	assign in_stby = state_next == lpmc_pkg::LPMC_ST_STANDBY;
	assign in_sleep = state_next == lpmc_pkg::LPMC_ST_SLEEP;
	assign in_rst = state_next == lpmc_pkg::LPMC_ST_RESET;
	assign ctrl_next.cpu_clk_en = ~(in_sleep | in_stop | in_stby |
		in_rst);
	assign ctrl_next.core_clk_en = ~(in_stop | in_stby);
	assign ctrl_next.pll_en = ~(in_stop | in_stby);
	assign ctrl_next.rc_osc_en = ~(in_stop | in_stby);
	assign ctrl_next.xtal_osc_en = ~(in_stop | in_stby);
	assign ctrl_next.reg_on = ~in_stby;
	assign ctrl_next.reg_low_power = in_stop & lp_reg_next;
	assign ctrl_next.core_reset = in_rst | in_stby;
	// Backup supply switch; strap open means no battery mode at all
	logic batt_next;
	assign batt_next = battery_only & strap_s;
	// Registered outputs so the domain controls never glitch
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= lpmc_pkg::LPMC_CTRL_RESET;
			state <= lpmc_pkg::LPMC_ST_RESET;
			backup_from_battery <= 1'b0;
			backup_retain <= 1'b0;
		end else begin
			ctrl <= ctrl_next;
			state <= state_next;
			backup_from_battery <= batt_next;
			backup_retain <= strap_s | vdd_s;
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_sleep_evt;
		state == lpmc_pkg::LPMC_ST_SLEEP && periph_event;
	endsequence
	property p_sleep_wake;
		@(posedge mclk) disable iff (rst)
		s_sleep_evt |=> state == lpmc_pkg::LPMC_ST_RUN;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake)
		else $error("sleep not left on event");
	property p_sleep_clk;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_SLEEP |->
			!ctrl.cpu_clk_en && ctrl.core_clk_en && ctrl.pll_en;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk)
		else $error("sleep gates wrong clocks");
	property p_stop_off;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_STOP |-> !ctrl.core_clk_en &&
			!ctrl.pll_en && !ctrl.rc_osc_en && !ctrl.xtal_osc_en &&
			ctrl.reg_on && !ctrl.core_reset;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("stop controls wrong");
	property p_stop_reg;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_RUN && enter_req &&
			enter_mode == lpmc_pkg::LPMC_MODE_STOP |=>
			ctrl.reg_low_power == $past(stop_lp_reg);
	endproperty
	a_stop_reg: assert property (p_stop_reg)
		else $error("stop regulator choice lost");
	property p_stop_wake;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_STOP && stop_wake |=>
			state == lpmc_pkg::LPMC_ST_RUN;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("stop not left on line");
	property p_stby_off;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_STANDBY |-> !ctrl.reg_on &&
			!ctrl.pll_en && ctrl.core_reset;
	endproperty
	a_stby_off: assert property (p_stby_off)
		else $error("standby controls wrong");
	property p_bypass;
		@(posedge mclk) disable iff (rst)
		bypass_s |=> state != lpmc_pkg::LPMC_ST_STANDBY ||
			$past(state) == lpmc_pkg::LPMC_ST_STANDBY;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("standby entered while bypassed");
	property p_batt;
		@(posedge mclk) disable iff (rst)
		battery_only && wake_s != '0 && !wdg_s && external_reset_pin_n_s &&
			state == lpmc_pkg::LPMC_ST_STOP |=>
			state == lpmc_pkg::LPMC_ST_STOP;
	endproperty
	a_batt: assert property (p_batt)
		else $error("battery mode left on interrupt");
	sequence s_rst_seq;
		// Ten cycles in reset, split to keep the repeat count small
		(state == lpmc_pkg::LPMC_ST_RESET) [*8] ##1
			(state == lpmc_pkg::LPMC_ST_RESET) [*2] ##1
			state == lpmc_pkg::LPMC_ST_RUN;
	endsequence
	property p_stby_exit;
		@(posedge mclk) disable iff (rst)
		state == lpmc_pkg::LPMC_ST_STANDBY && standby_wake |=>
			s_rst_seq;
	endproperty
	a_stby_exit: assert property (p_stby_exit)
		else $error("standby exit without reset sequence");
	property p_switch;
		@(posedge mclk) disable iff (rst)
		!$past(rst) |-> backup_from_battery ==
			($past(!vdd_s) && $past(strap_s));
	endproperty
	a_switch: assert property (p_switch)
		else $error("backup switch wrong");
endmodule

// >>> core/lpmc_pkg.sv
// Package for the low-power mode controller: modes, wake groups, counts
package lpmc_pkg;
	// ------------------------------------------------------------
	// Modes and sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LPMC_MODE_SLEEP,
		LPMC_MODE_STOP,
		LPMC_MODE_STANDBY
	} lpmc_mode_e;
	typedef enum logic [2:0] {
		LPMC_ST_RESET,
		LPMC_ST_RUN,
		LPMC_ST_SLEEP,
		LPMC_ST_STOP,
		LPMC_ST_STANDBY
	} lpmc_state_e;
	// ------------------------------------------------------------
	// Widths and timing counts
	// ------------------------------------------------------------
	localparam int LPMC_EXT_LINES = 16;
	localparam int LPMC_RESET_NS = 100;
	localparam int LPMC_CLK_NS = 10;
	localparam logic [7:0] LPMC_RESET_CYCLES =
		8'((LPMC_RESET_NS + LPMC_CLK_NS - 1) / LPMC_CLK_NS);
	// ------------------------------------------------------------
	// Wake sources grouped together
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ext_lines;
		logic supply_level;
		logic rtc_alarm;
		logic rtc_wakeup;
		logic rtc_tamper;
		logic rtc_timestamp;
	} lpmc_wake_s;
	// Domain controls driven out
	typedef struct packed {
		logic cpu_clk_en;
		logic core_clk_en;
		logic pll_en;
		logic rc_osc_en;
		logic xtal_osc_en;
		logic reg_on;
		logic reg_low_power;
		logic core_reset;
	} lpmc_ctrl_s;
	// Controls held in reset: regulator on, core held in reset
	localparam lpmc_ctrl_s LPMC_CTRL_RESET = 8'h05;
endpackage

// >>> test/low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
module low_power_mode_controller_tb;
	logic mclk = 1'b0, rst = 1'b1, enter_req = 1'b0, stop_lp_reg = 1'b0;
	lpmc_pkg::lpmc_mode_e enter_mode = lpmc_pkg::LPMC_MODE_SLEEP;
	logic periph_event = 1'b0, regulator_bypass = 1'b0, fire = 1'b0;
	logic main_supply_ok = 1'b1, power_down_reset_strap = 1'b1;
	logic [4:0] sel = 5'h0; // Partner source select
	lpmc_pkg::lpmc_wake_s wake_src;
	logic wakeup_pin, external_reset_pin_n, independent_watchdog;
	lpmc_pkg::lpmc_ctrl_s ctrl;
	lpmc_pkg::lpmc_state_e state;
	logic backup_from_battery, backup_retain;
	int bad_count = 0, cmp_count = 0, seed = 40, i;
	lpmc_ctrl dut (.mclk(mclk), .rst(rst), .enter_req(enter_req),
		.enter_mode(enter_mode), .stop_lp_reg(stop_lp_reg),
		.periph_event(periph_event), .wake_src(wake_src),
		.wakeup_pin(wakeup_pin), .external_reset_pin_n(external_reset_pin_n),
		.independent_watchdog(independent_watchdog),
		.regulator_bypass(regulator_bypass), .main_supply_ok(main_supply_ok),
		.power_down_reset_strap(power_down_reset_strap), .ctrl(ctrl),
		.state(state), .backup_from_battery(backup_from_battery),
		.backup_retain(backup_retain));
	lpmc_partner far_side (.mclk(mclk), .fire(fire), .sel(sel),
		.wake_src(wake_src), .wakeup_pin(wakeup_pin),
		.external_reset_pin_n(external_reset_pin_n),
		.independent_watchdog(independent_watchdog));
	// ------------------------------------------------------------
	// Model and compare tasks
	// ------------------------------------------------------------
	// Expected controls per state; standby holds the core in reset
	function automatic logic [7:0] m_ctrl(lpmc_pkg::lpmc_state_e s, logic lp);
		case (s)
			lpmc_pkg::LPMC_ST_RUN: m_ctrl = 8'hfc;
			lpmc_pkg::LPMC_ST_SLEEP: m_ctrl = 8'h7c;
			lpmc_pkg::LPMC_ST_STOP: m_ctrl = {6'h01, lp, 1'b0};
			lpmc_pkg::LPMC_ST_STANDBY: m_ctrl = 8'h01;
			default: m_ctrl = 8'h05;
		endcase
	endfunction
	task automatic chk_st(lpmc_pkg::lpmc_state_e e);
		cmp_count++;
		if (state !== e) begin
			bad_count++;
			$display("ERROR %0t state %0d want %0d", $time, state, e);
		end
	endtask
	task automatic chk_ctrl(logic [7:0] e, logic [7:0] m);
		cmp_count++;
		if ((8'(ctrl) & m) !== (e & m)) begin
			bad_count++;
			$display("ERROR %0t ctrl %h want %h", $time, ctrl, e);
		end
	endtask
	task automatic chk_bit(logic g, logic e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t backup flag %b want %b", $time, g, e);
		end
	endtask
	// Requests are one-cycle pulses launched at the falling edge
	task automatic enter(lpmc_pkg::lpmc_mode_e md);
		enter_mode = md;
		enter_req = 1'b1;
		@(negedge mclk);
		enter_req = 1'b0;
	endtask
	task automatic wake(int s);
		sel = 5'(s);
		fire = 1'b1;
		@(negedge mclk);
		fire = 1'b0;
	endtask
	// Bounded wait, so a stuck state shows as a mismatch
	task automatic wait_st(lpmc_pkg::lpmc_state_e e, int n);
		repeat (n) if (state !== e) @(negedge mclk);
		chk_st(e);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ------------------------------------------------------------
	initial forever #5 mclk = ~mclk;
	// The whole run needs about 530 cycles
	initial begin
		#100000;
		bad_count++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		repeat (16) @(negedge mclk);
		chk_st(lpmc_pkg::LPMC_ST_RESET);
		chk_ctrl(8'h05, 8'hff);
		rst = 1'b0;
		wait_st(lpmc_pkg::LPMC_ST_RUN, 14);
		chk_ctrl(m_ctrl(lpmc_pkg::LPMC_ST_RUN, 1'b0), 8'hff);
		$display("reset test done");
		enter(lpmc_pkg::LPMC_MODE_SLEEP);
		chk_ctrl(m_ctrl(lpmc_pkg::LPMC_ST_SLEEP, 1'b0), 8'hff);
		wake(0);
		repeat (6) @(negedge mclk);
		chk_st(lpmc_pkg::LPMC_ST_SLEEP);
		periph_event = 1'b1;
		@(negedge mclk);
		periph_event = 1'b0;
		chk_st(lpmc_pkg::LPMC_ST_RUN);
		$display("sleep test done");
		// Every interrupt-controller line, random regulator choice
		for (i = 0; i < 21; i++) begin
			stop_lp_reg = 1'($random(seed));
			enter(lpmc_pkg::LPMC_MODE_STOP);
			chk_ctrl(m_ctrl(lpmc_pkg::LPMC_ST_STOP, stop_lp_reg), 8'hff);
			@(negedge mclk);
			enter(lpmc_pkg::LPMC_MODE_STANDBY);
			chk_st(lpmc_pkg::LPMC_ST_STOP);
			wake(i);
			wait_st(lpmc_pkg::LPMC_ST_RUN, 8);
			repeat (6) @(negedge mclk);
		end
		$display("stop test done");
		regulator_bypass = 1'b1;
		repeat (3) @(negedge mclk);
		enter(lpmc_pkg::LPMC_MODE_STANDBY);
		chk_st(lpmc_pkg::LPMC_ST_RUN);
		regulator_bypass = 1'b0;
		repeat (3) @(negedge mclk);
		// Standby exits: rtc events, pin, reset pin, watchdog
		for (i = 17; i < 24; i++) begin
			enter(lpmc_pkg::LPMC_MODE_STANDBY);
			chk_st(lpmc_pkg::LPMC_ST_STANDBY);
			chk_ctrl(8'h01, 8'hff);
			chk_bit(backup_retain, 1'b1);
			wake(i);
			wait_st(lpmc_pkg::LPMC_ST_RESET, 8);
			chk_ctrl(8'h01, 8'h81);
			wait_st(lpmc_pkg::LPMC_ST_RUN, 16);
			repeat (6) @(negedge mclk);
		end
		$display("standby test done");
		main_supply_ok = 1'b0;
		repeat (4) @(negedge mclk);
		chk_bit(backup_from_battery, 1'b1);
		// Stop on battery alone: lines are blind, only reset leaves
		enter(lpmc_pkg::LPMC_MODE_STOP);
		wake(0);
		repeat (8) @(negedge mclk);
		chk_st(lpmc_pkg::LPMC_ST_STOP);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		chk_st(lpmc_pkg::LPMC_ST_RESET);
		chk_ctrl(8'h05, 8'hff);
		rst = 1'b0;
		wait_st(lpmc_pkg::LPMC_ST_RUN, 14);
		enter(lpmc_pkg::LPMC_MODE_STANDBY);
		wake(21);
		repeat (8) @(negedge mclk);
		wake(17);
		repeat (8) @(negedge mclk);
		chk_st(lpmc_pkg::LPMC_ST_STANDBY);
		wake(23);
		wait_st(lpmc_pkg::LPMC_ST_RESET, 8);
		wait_st(lpmc_pkg::LPMC_ST_RUN, 16);
		main_supply_ok = 1'b1;
		repeat (4) @(negedge mclk);
		chk_bit(backup_from_battery, 1'b0);
		// Strap open: battery pin held at the main supply
		power_down_reset_strap = 1'b0;
		repeat (4) @(negedge mclk);
		chk_bit(backup_from_battery, 1'b0);
		// Main supply gone with strap open: no battery domain at all
		main_supply_ok = 1'b0;
		repeat (4) @(negedge mclk);
		chk_bit(backup_from_battery, 1'b0);
		chk_bit(backup_retain, 1'b0);
		$display("battery test done");
		close_out();
	end
endmodule

// >>> test/lpmc_partner.sv
// Model of the wake pins, interrupt lines and reset sources
`timescale 1ns/1ps
module lpmc_partner (
	input wire logic mclk, // System clock
	input wire logic fire, // Start one wake pulse
	input wire logic [4:0] sel, // Source to pulse
	output lpmc_pkg::lpmc_wake_s wake_src, // Interrupt-line sources
	output logic wakeup_pin, // Wake pin, idle low
	output logic external_reset_pin_n, // Reset pin, idle high
	output logic independent_watchdog // Watchdog reset, idle low
);
	logic [2:0] hold_reg = 3'h0; // Pulse cycles left
	logic [4:0] sel_reg = 5'h0; // Latched source
	wire on = hold_reg != 3'h0; // Pulse in progress
	// ------------------------------------------------------------
	// Pulse timing: four cycles, long enough for the two-flop sync
	// ------------------------------------------------------------
	// Fire is driven at the falling edge, so sample it on the rising one
	always @(posedge mclk) begin
		if (fire) begin
			hold_reg <= 3'h4;
			sel_reg <= sel;
		end else if (on) begin
			hold_reg <= hold_reg - 3'h1;
		end
	end
	// Map: 0-15 lines, 16 supply, 17-20 rtc, 21 pin, 22 reset, 23 dog
	always_comb begin
		wake_src = '0;
		if (on && sel_reg < 5'h15) begin
			wake_src[sel_reg < 5'h10 ? 5'h5 + sel_reg : 5'h14 - sel_reg] = 1'b1;
		end
		wakeup_pin = on && sel_reg == 5'h15;
		external_reset_pin_n = !(on && sel_reg == 5'h16);
		independent_watchdog = on && sel_reg == 5'h17;
	end
endmodule
